// *** shared/xbps_pkg.sv ***
// Package with constants for the bus peripheral select block
package xbps_pkg;
	localparam int          ADDR_W          = 24;
	localparam int          REG_ADDR_W      = 16;
	localparam int          DATA_W          = 16;
	// Register offsets
	localparam logic [15:0] OFF_PERIPH_EN   = 16'hF024;
	localparam logic [15:0] OFF_SYS_CONFIG  = 16'hF0F0;
	localparam logic [15:0] OFF_RTC_CONTROL = 16'hF0F2;
	localparam logic [15:0] OFF_STATUS      = 16'hF0F4;
	// Enable register fields
	localparam int          BIT_CAN_A       = 0;
	localparam int          BIT_CAN_B       = 1;
	localparam int          BIT_SMALL_RAM   = 2;
	localparam int          BIT_LARGE_RAM   = 3;
	localparam int          BIT_RTC         = 4;
	localparam int          EN_W            = 5;
	localparam logic [4:0]  EN_RESET        = 5'h05;
	localparam logic [4:0]  EN_ALL          = 5'h1F;
	// System configuration and clock control fields
	localparam int          BIT_GLOBAL_EN   = 0;
	localparam int          BIT_OSC_OFF     = 0;
	// Address windows, inclusive
	localparam logic [23:0] CAN_A_LO        = 24'h00_EF00;
	localparam logic [23:0] CAN_A_HI        = 24'h00_EFFF;
	localparam logic [23:0] CAN_B_LO        = 24'h00_EE00;
	localparam logic [23:0] CAN_B_HI        = 24'h00_EEFF;
	localparam logic [23:0] SMALL_RAM_LO    = 24'h00_E000;
	localparam logic [23:0] SMALL_RAM_HI    = 24'h00_E7FF;
	localparam logic [23:0] LARGE_RAM_LO    = 24'h00_C000;
	localparam logic [23:0] LARGE_RAM_HI    = 24'h00_DFFF;
	localparam logic [23:0] RTC_LO          = 24'h00_EC00;
	localparam logic [23:0] RTC_HI          = 24'h00_ECFF;
	// Access target encoding
	typedef enum logic [2:0] {
		XBPS_TGT_NONE  = 3'h0,
		XBPS_TGT_EXT   = 3'h1,
		XBPS_TGT_CAN_A = 3'h2,
		XBPS_TGT_CAN_B = 3'h3,
		XBPS_TGT_SRAM  = 3'h4,
		XBPS_TGT_LRAM  = 3'h5,
		XBPS_TGT_RTC   = 3'h6
	} xbps_target_t;
endpackage

// *** shared/xbps_en_if.sv ***
// Interface carrying effective enables between register file and decoder
`timescale 1ns/1ps
interface xbps_en_if;
	logic [4:0] effEnable;
	modport src (output effEnable);
	modport dst (input effEnable);
endinterface

// *** core/xbps_win_match.sv ***
// Inclusive address window comparator
`timescale 1ns/1ps
module xbps_win_match
	import xbps_pkg::*;
#(
	parameter logic [23:0] LO = 24'h00_0000,
	parameter logic [23:0] HI = 24'h00_0000
) (
	input  wire logic [23:0] addr,
	output logic             hit
);
	assign hit = (addr >= LO) && (addr <= HI);
endmodule

// *** core/xbps_decode.sv ***
// Address steering between on-chip peripherals and the external bus
`timescale 1ns/1ps
module xbps_decode
	import xbps_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          rst,
	xbps_en_if.dst             en,
	input  wire logic [23:0]   accAddr,
	input  wire logic          accReq,
	output xbps_target_t       accTarget_r,
	output logic               accValid_r
);
	logic hitA;
	logic hitB;
	logic hitS;
	logic hitL;
	logic hitR;
	logic bothCanOff;
	xbps_target_t tgtNxt;

	xbps_win_match #(.LO(CAN_A_LO), .HI(CAN_A_HI)) uA (.addr(accAddr), .hit(hitA));
	xbps_win_match #(.LO(CAN_B_LO), .HI(CAN_B_HI)) uB (.addr(accAddr), .hit(hitB));
	xbps_win_match #(.LO(SMALL_RAM_LO), .HI(SMALL_RAM_HI)) uS (.addr(accAddr), .hit(hitS));
	xbps_win_match #(.LO(LARGE_RAM_LO), .HI(LARGE_RAM_HI)) uL (.addr(accAddr), .hit(hitL));
	xbps_win_match #(.LO(RTC_LO), .HI(RTC_HI)) uR (.addr(accAddr), .hit(hitR));

	assign bothCanOff = !en.effEnable[BIT_CAN_A] && !en.effEnable[BIT_CAN_B];

	// Blocked windows that do not reach the external bus answer nobody
	always_comb begin
		tgtNxt = XBPS_TGT_EXT;
		if (hitA) begin
			if (en.effEnable[BIT_CAN_A])
				tgtNxt = XBPS_TGT_CAN_A;
			else if (bothCanOff)
				tgtNxt = XBPS_TGT_EXT;
			else
				tgtNxt = XBPS_TGT_NONE;
		end else if (hitB) begin
			if (en.effEnable[BIT_CAN_B])
				tgtNxt = XBPS_TGT_CAN_B;
			else if (bothCanOff)
				tgtNxt = XBPS_TGT_EXT;
			else
				tgtNxt = XBPS_TGT_NONE;
		end else if (hitR) begin
			if (en.effEnable[BIT_RTC])
				tgtNxt = XBPS_TGT_RTC;
			else if (bothCanOff)
				tgtNxt = XBPS_TGT_EXT;
			else
				tgtNxt = XBPS_TGT_NONE;
		end else if (hitS) begin
			tgtNxt = en.effEnable[BIT_SMALL_RAM] ? XBPS_TGT_SRAM : XBPS_TGT_EXT;
		end else if (hitL) begin
			tgtNxt = en.effEnable[BIT_LARGE_RAM] ? XBPS_TGT_LRAM : XBPS_TGT_EXT;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			accTarget_r <= XBPS_TGT_NONE;
			accValid_r  <= 1'b0;
		end else begin
			accTarget_r <= accReq ? tgtNxt : XBPS_TGT_NONE;
			accValid_r  <= accReq;
		end
	end

	a_ext_can_window: assert property (@(posedge mclk) disable iff (rst)
		accReq && hitA && !bothCanOff && !en.effEnable[BIT_CAN_A]
		|=> accTarget_r == XBPS_TGT_NONE)
		else $error("CAN A window reached external bus with a CAN enabled");
	a_ext_both_off: assert property (@(posedge mclk) disable iff (rst)
		accReq && (hitA || hitB) && bothCanOff |=> accTarget_r == XBPS_TGT_EXT)
		else $error("CAN windows not external with both CANs off");
	a_canb_window: assert property (@(posedge mclk) disable iff (rst)
		accReq && hitB && !en.effEnable[BIT_CAN_B] && en.effEnable[BIT_CAN_A]
		|=> accTarget_r == XBPS_TGT_NONE)
		else $error("CAN B window not blocked");
	a_small_ram: assert property (@(posedge mclk) disable iff (rst)
		accReq && hitS |=> accTarget_r ==
		($past(en.effEnable[BIT_SMALL_RAM]) ? XBPS_TGT_SRAM : XBPS_TGT_EXT))
		else $error("Small RAM window steered wrongly");
	a_large_ram: assert property (@(posedge mclk) disable iff (rst)
		accReq && hitL |=> accTarget_r ==
		($past(en.effEnable[BIT_LARGE_RAM]) ? XBPS_TGT_LRAM : XBPS_TGT_EXT))
		else $error("Large RAM window steered wrongly");
	a_rtc_window: assert property (@(posedge mclk) disable iff (rst)
		accReq && hitR && !en.effEnable[BIT_RTC] |=> accTarget_r ==
		($past(bothCanOff) ? XBPS_TGT_EXT : XBPS_TGT_NONE))
		else $error("RTC window steered wrongly");
endmodule

// *** core/xbps_periph_select.sv ***
// Bus peripheral enable register and address steering top
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module xbps_periph_select
	import xbps_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic [15:0]   regAddr,
	input  wire logic [15:0]   regWdata,
	input  wire logic          regWr,
	input  wire logic          regRd,
	output logic      [15:0]   regRdata,
	input  wire logic          emulMode,
	input  wire logic          powerDown,
	input  wire logic [23:0]   accAddr,
	input  wire logic          accReq,
	output xbps_target_t       accTarget,
	output logic               accValid,
	output logic               canAEnable,
	output logic               canBEnable,
	output logic               smallRamEnable,
	output logic               largeRamEnable,
	output logic               rtcUnitEnable,
	output logic [3:0]         port4GpioFree,
	output logic               oscOff
);
	logic [4:0]  periphEnable_r;
	logic        globalEnable_r;
	logic        oscOffBit_r;
	logic [15:0] regRdata_r;
	logic [15:0] rdNxt;
	logic [4:0]  effEn;
	logic        emulSync1_r;
	logic        emulSync2_r;
	logic        pdSync1_r;
	logic        pdSync2_r;
	logic        oscOff_r;
	xbps_en_if   enBus ();

	// Mode pins come from outside the clock domain
	always_ff @(posedge mclk) begin
		if (rst) begin
			emulSync1_r <= 1'b0;
			emulSync2_r <= 1'b0;
			pdSync1_r   <= 1'b0;
			pdSync2_r   <= 1'b0;
		end else begin
			emulSync1_r <= emulMode;
			emulSync2_r <= emulSync1_r;
			pdSync1_r   <= powerDown;
			pdSync2_r   <= pdSync1_r;
		end
	end

	// Enable register; the lock is one-way until reset
	always_ff @(posedge mclk) begin
		if (rst) begin
			periphEnable_r <= EN_RESET;
		end else if (regWr && regAddr == OFF_PERIPH_EN && !globalEnable_r) begin
			periphEnable_r <= regWdata[EN_W-1:0];
		end
	end

	// Global enable can only be set, never cleared, by software
	always_ff @(posedge mclk) begin
		if (rst) begin
			globalEnable_r <= 1'b0;
		end else if (regWr && regAddr == OFF_SYS_CONFIG && regWdata[BIT_GLOBAL_EN]) begin
			globalEnable_r <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			oscOffBit_r <= 1'b0;
		end else if (regWr && regAddr == OFF_RTC_CONTROL) begin
			oscOffBit_r <= regWdata[BIT_OSC_OFF];
		end
	end

	// Emulation overrides the stored value without touching it
	assign effEn = emulSync2_r ? EN_ALL : periphEnable_r;
	assign enBus.effEnable = effEn;

	always_comb begin
		rdNxt = 16'h0000;
		unique case (regAddr)
			OFF_PERIPH_EN:   rdNxt = {11'h000, periphEnable_r};
			OFF_SYS_CONFIG:  rdNxt = {15'h0000, globalEnable_r};
			OFF_RTC_CONTROL: rdNxt = {15'h0000, oscOffBit_r};
			OFF_STATUS:      rdNxt = {11'h000, effEn};
			default:         rdNxt = 16'h0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdata_r <= 16'h0000;
		end else if (regRd) begin
			regRdata_r <= rdNxt;
		end else begin
			regRdata_r <= 16'h0000;
		end
	end
	assign regRdata = regRdata_r;

	// Oscillator control in power-down
	always_ff @(posedge mclk) begin
		if (rst) begin
			oscOff_r <= 1'b0;
		end else if (!pdSync2_r) begin
			oscOff_r <= 1'b0;
		end else if (!effEn[BIT_RTC]) begin
			oscOff_r <= 1'b1;
		end else begin
			oscOff_r <= oscOffBit_r;
		end
	end
	assign oscOff = oscOff_r;

	assign canAEnable     = effEn[BIT_CAN_A];
	assign canBEnable     = effEn[BIT_CAN_B];
	assign smallRamEnable = effEn[BIT_SMALL_RAM];
	assign largeRamEnable = effEn[BIT_LARGE_RAM];
	assign rtcUnitEnable  = effEn[BIT_RTC];
	// Index 0..3 = port 4 pins 4, 5, 6, 7
	assign port4GpioFree  = {!effEn[BIT_CAN_B], !effEn[BIT_CAN_A],
	                         !effEn[BIT_CAN_A], !effEn[BIT_CAN_B]};

	xbps_decode uDec (
		.mclk        (mclk),
		.rst         (rst),
		.en          (enBus.dst),
		.accAddr     (accAddr),
		.accReq      (accReq),
		.accTarget_r (accTarget),
		.accValid_r  (accValid)
	);

	a_reset_value: assert property (@(posedge mclk)
		rst |=> periphEnable_r == EN_RESET)
		else $error("Enable register not 05h after reset");
	a_lock_after_global: assert property (@(posedge mclk) disable iff (rst)
		globalEnable_r |=> $stable(periphEnable_r))
		else $error("Enable register changed after global enable");
	a_emul_all_on: assert property (@(posedge mclk) disable iff (rst)
		emulSync2_r |-> effEn == EN_ALL)
		else $error("Emulation mode did not force enables");
	a_unused_zero: assert property (@(posedge mclk) disable iff (rst)
		regRd && regAddr == OFF_PERIPH_EN |=> regRdata[15:EN_W] == 11'h000)
		else $error("Unused enable bits read nonzero");
	a_write_takes: assert property (@(posedge mclk) disable iff (rst)
		regWr && regAddr == OFF_PERIPH_EN && !globalEnable_r
		|=> periphEnable_r == $past(regWdata[EN_W-1:0]))
		else $error("Enable write lost while unlocked");
	a_osc_rtc_off: assert property (@(posedge mclk) disable iff (rst)
		pdSync2_r && !effEn[BIT_RTC] |=> oscOff)
		else $error("Oscillator left running in power-down");
	a_osc_follow_bit: assert property (@(posedge mclk) disable iff (rst)
		pdSync2_r && effEn[BIT_RTC] |=> oscOff == $past(oscOffBit_r))
		else $error("Oscillator ignores off bit");
	a_gpio_free: assert property (@(posedge mclk) disable iff (rst)
		port4GpioFree[1] == !canAEnable && port4GpioFree[0] == !canBEnable)
		else $error("Port 4 release mismatch");
	a_gpio_upper: assert property (@(posedge mclk) disable iff (rst)
		port4GpioFree[2] == !canAEnable && port4GpioFree[3] == !canBEnable)
		else $error("Port 4 upper release mismatch");
	a_locked_write: assert property (@(posedge mclk) disable iff (rst)
		regWr && regAddr == OFF_PERIPH_EN && globalEnable_r
		|=> periphEnable_r == $past(periphEnable_r))
		else $error("Locked enable register took a write");
	a_global_set: assert property (@(posedge mclk) disable iff (rst)
		regWr && regAddr == OFF_SYS_CONFIG && regWdata[BIT_GLOBAL_EN] |=> globalEnable_r)
		else $error("Global enable not set by write");
	a_emul_off_stored: assert property (@(posedge mclk) disable iff (rst)
		!emulSync2_r |-> effEn == periphEnable_r)
		else $error("Effective enables differ from register");
	a_enable_readback: assert property (@(posedge mclk) disable iff (rst)
		regRd && regAddr == OFF_PERIPH_EN |=> regRdata == {11'h000, $past(periphEnable_r)})
		else $error("Enable register read back wrongly");
	a_status_read: assert property (@(posedge mclk) disable iff (rst)
		regRd && regAddr == OFF_STATUS |=> regRdata == {11'h000, $past(effEn)})
		else $error("Status read back wrongly");
	// Read data must not linger, software may poll any offset
	a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
		!regRd |=> regRdata == 16'h0000)
		else $error("Read data not zero outside a read");
	a_osc_awake: assert property (@(posedge mclk) disable iff (rst)
		!pdSync2_r |=> !oscOff)
		else $error("Oscillator off outside power-down");
	a_rtc_control: assert property (@(posedge mclk) disable iff (rst)
		regWr && regAddr == OFF_RTC_CONTROL |=> oscOffBit_r == $past(regWdata[BIT_OSC_OFF]))
		else $error("Oscillator off bit not written");
endmodule

// *** verification/xbps_ext_bus_model.sv ***
// External memory bus controller model that tallies steered accesses
`timescale 1ns/1ps
module xbps_ext_bus_model
	import xbps_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         accValid,
	input  wire xbps_target_t accTarget,
	output int                extCount
);
	// Counts only what the steering hands over; windows steered to XBPS_TGT_NONE never reach it
	always_ff @(posedge mclk) begin
		if (rst) begin
			extCount <= 0;
		end else if (accValid && accTarget === XBPS_TGT_EXT) begin
			extCount <= extCount + 1;
		end
	end
endmodule

// *** verification/xbps_periph_select_tb.sv ***
// Self-checking bench for the peripheral enable register and steering
`timescale 1ns/1ps
module xbps_periph_select_tb
	import xbps_pkg::*;
;
	logic         mclk, rst, regWr, regRd, emulMode, powerDown, accReq;
	logic         canAEnable, canBEnable, smallRamEnable, largeRamEnable;
	logic         rtcUnitEnable, oscOff, accValid;
	logic [15:0]  regAddr, regWdata, regRdata, d;
	logic [23:0]  accAddr;
	logic [3:0]   port4GpioFree;
	xbps_target_t accTarget;
	int           fails, nChecks, extCount, extExp, seed, i, j;
	logic [23:0]  adr [14] = '{24'h00_BFFF, 24'h00_C000, 24'h00_DFFF, 24'h00_E000,
		24'h00_E7FF, 24'h00_E800, 24'h00_EC00, 24'h00_ECFF, 24'h00_EDFF,
		24'h00_EE00, 24'h00_EEFF, 24'h00_EF00, 24'h00_EFFF, 24'h01_EF00};

	xbps_periph_select i_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.emulMode(emulMode), .powerDown(powerDown), .accAddr(accAddr),
		.accReq(accReq), .accTarget(accTarget), .accValid(accValid),
		.canAEnable(canAEnable), .canBEnable(canBEnable),
		.smallRamEnable(smallRamEnable), .largeRamEnable(largeRamEnable),
		.rtcUnitEnable(rtcUnitEnable), .port4GpioFree(port4GpioFree),
		.oscOff(oscOff));
	xbps_ext_bus_model i_ext (.mclk(mclk), .rst(rst), .accValid(accValid),
		.accTarget(accTarget), .extCount(extCount));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		nChecks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", nChecks, fails);
		if (fails == 0 && nChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		@(posedge mclk);
		regAddr  <= a;
		regWdata <= v;
		regWr    <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	// Read data are valid only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		@(posedge mclk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask

	// Reference steering, windows in the priority the design documents
	function automatic int tgt(input logic [4:0] e, input logic [23:0] a);
		if (a >= CAN_A_LO && a <= CAN_A_HI) return e[0] ? 2 : (e[1] ? 0 : 1);
		if (a >= CAN_B_LO && a <= CAN_B_HI) return e[1] ? 3 : (e[0] ? 0 : 1);
		if (a >= RTC_LO && a <= RTC_HI) return e[4] ? 6 : ((e[0] | e[1]) ? 0 : 1);
		if (a >= SMALL_RAM_LO && a <= SMALL_RAM_HI) return e[2] ? 4 : 1;
		if (a >= LARGE_RAM_LO && a <= LARGE_RAM_HI) return e[3] ? 5 : 1;
		return 1;
	endfunction

	task automatic acc(input logic [4:0] e, input logic [23:0] a);
		int t;
		t = tgt(e, a);
		@(posedge mclk);
		accAddr <= a;
		accReq  <= 1'b1;
		@(posedge mclk);
		accReq <= 1'b0;
		#1;
		chk("accValid", 16'h0001, {15'h0000, accValid});
		chk("accTarget", t[15:0], {13'h0000, accTarget});
		if (t == 1) extExp++;
	endtask

	task automatic cfg(input logic [4:0] e);
		chk("enables", {11'h000, e}, {11'h000, rtcUnitEnable, largeRamEnable,
			smallRamEnable, canBEnable, canAEnable});
		chk("gpioFree", {12'h000, ~e[1], ~e[0], ~e[0], ~e[1]},
			{12'h000, port4GpioFree});
		for (j = 0; j < 14; j++) acc(e, adr[j]);
		acc(e, {8'h00, 2'b11, 14'($random(seed))});
		@(posedge mclk);
		#1 chk("idleTarget", 16'h0000, {12'h000, accValid, accTarget});
	endtask

	initial begin
		#1_000_000;
		fails++;
		close_out();
	end

	initial begin
		seed = 32'h8f38_844d;
		{regWr, regRd, emulMode, powerDown, accReq} = 5'h00;
		regAddr  = 16'h0000;
		regWdata = 16'h0000;
		accAddr  = 24'h00_0000;
		rst      = 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(OFF_PERIPH_EN, d);
		chk("resetValue", 16'h0005, d);
		cfg(5'h05);
		for (i = 0; i < 32; i++) begin
			wr(OFF_PERIPH_EN, 16'({$random(seed)}) & 16'hFFE0 | 16'(i));
			rd(OFF_PERIPH_EN, d);
			chk("periphEnable", 16'(i), d);
			cfg(5'(i));
		end
		@(posedge mclk);
		powerDown <= 1'b1;
		for (i = 0; i < 4; i++) begin
			wr(OFF_PERIPH_EN, {11'h000, i[1], 4'h5});
			wr(OFF_RTC_CONTROL, {15'h0000, i[0]});
			rd(OFF_RTC_CONTROL, d);
			chk("rtcControl", {15'h0000, i[0]}, d);
			repeat (5) @(posedge mclk);
			#1 chk("oscOff", {15'h0000, ~i[1] | i[0]}, {15'h0000, oscOff});
		end
		powerDown <= 1'b0;
		wr(OFF_PERIPH_EN, 16'h0000);
		emulMode <= 1'b1;
		repeat (4) @(posedge mclk);
		cfg(EN_ALL);
		rd(OFF_STATUS, d);
		chk("status", {11'h000, EN_ALL}, d);
		rd(OFF_PERIPH_EN, d);
		chk("storedEnable", 16'h0000, d);
		emulMode <= 1'b0;
		repeat (4) @(posedge mclk);
		wr(OFF_SYS_CONFIG, 16'h0001);
		rd(OFF_SYS_CONFIG, d);
		chk("globalEnable", 16'h0001, d);
		wr(OFF_PERIPH_EN, 16'hFFFF);
		rd(OFF_PERIPH_EN, d);
		chk("lockedEnable", 16'h0000, d);
		cfg(5'h00);
		rd(16'h1234, d);
		chk("unmapped", 16'h0000, d);
		chk("extCount", extExp[15:0], extCount[15:0]);
		@(posedge mclk);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rd(OFF_PERIPH_EN, d);
		chk("resetAgain", 16'h0005, d);
		cfg(EN_RESET);
		wr(OFF_PERIPH_EN, 16'h000A);
		rd(OFF_PERIPH_EN, d);
		chk("unlocked", 16'h000A, d);
		close_out();
	end
endmodule
